/* File: shared/afp_defines.svh */
// Register offsets, field positions, reset values and timing figures of the fan parameter block
`ifndef AFP_DEFINES_SVH
`define AFP_DEFINES_SVH
// Register offsets on the management port
`define AFP_ADDR_RANGE1 8'h5F
`define AFP_ADDR_RANGE2 8'h60
`define AFP_ADDR_RANGE3 8'h61
`define AFP_ADDR_OFFMIN_Z1 8'h62
`define AFP_ADDR_Z2_Z3 8'h63
`define AFP_ADDR_MIN1 8'h64
`define AFP_ADDR_MIN2 8'h65
`define AFP_ADDR_MIN3 8'h66
// Reset values and the full and zero duty codes
`define AFP_RANGE_RST 8'hC4
`define AFP_SMOOTH_RST 8'h00
`define AFP_MIN_RST 8'h80
`define AFP_FULL_DUTY 8'hFF
`define AFP_ZERO_DUTY 8'h00
// Field positions
`define AFP_RANGE_LSB 4
`define AFP_BELOW_SEL_LSB 5
`define AFP_Z1_EN_BIT 3
`define AFP_Z2_EN_BIT 7
`define AFP_Z3_EN_BIT 3
`define AFP_Z1_TIME_LSB 0
`define AFP_Z2_TIME_LSB 4
`define AFP_Z3_TIME_LSB 0
// Smoothing periods in tenths of a second, codes 000 to 111
`define AFP_SMOOTH_DS_0 350
`define AFP_SMOOTH_DS_1 176
`define AFP_SMOOTH_DS_2 118
`define AFP_SMOOTH_DS_3 70
`define AFP_SMOOTH_DS_4 44
`define AFP_SMOOTH_DS_5 30
`define AFP_SMOOTH_DS_6 16
`define AFP_SMOOTH_DS_7 8
// Fixed-point scale of the filter gain and the slope, and the last PWM count
`define AFP_UNITY 65536
`define AFP_PWM_LAST 8'hFE
`endif

/* File: shared/afp_pkg.sv */
// Types shared by the fan parameter block
package afp_pkg;
  typedef logic [7:0] afp_byte_t;
  typedef logic [3:0] afp_range_t;
  typedef logic [2:0] afp_stime_t;
  typedef logic [15:0] afp_gain_t;
endpackage : afp_pkg

/* File: hw/afp_smooth.sv */
// Low-pass smoothing of one zone's control temperature
`timescale 1ns/1ps
`default_nettype none
`include "afp_defines.svh"
module afp_smooth
  import afp_pkg::*;
#(
  parameter int SAMPLE_DS = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Raw sample stream
  input wire logic temp_stb,
  input wire afp_byte_t temp_raw,
  // Settings
  input wire logic smooth_en,
  input wire afp_stime_t smooth_time,
  // Filtered control temperature
  output afp_byte_t temp_ctl
);

  // Gain per sample is sample period over settling time, capped at 65535, one step under unity
  function automatic afp_gain_t smooth_gain(input afp_stime_t code);
    int tau;
    int g;
    begin
      unique case (code)
        3'd0: tau = `AFP_SMOOTH_DS_0;
        3'd1: tau = `AFP_SMOOTH_DS_1;
        3'd2: tau = `AFP_SMOOTH_DS_2;
        3'd3: tau = `AFP_SMOOTH_DS_3;
        3'd4: tau = `AFP_SMOOTH_DS_4;
        3'd5: tau = `AFP_SMOOTH_DS_5;
        3'd6: tau = `AFP_SMOOTH_DS_6;
        3'd7: tau = `AFP_SMOOTH_DS_7;
      endcase
      g = (SAMPLE_DS * `AFP_UNITY) / tau; // see [R09]
      if (g > 65535) begin
        g = 65535;
      end
      return 16'(g);
    end
  endfunction : smooth_gain

  logic [15:0] acc_q; // Temperature in 8.8 fixed point
  logic [15:0] acc_d;
  logic signed [16:0] diff; // Sample minus running value
  logic signed [33:0] prod;
  logic signed [17:0] step;

  // Next value: bypass copies the sample, enabled mode moves a fraction toward it
  always_comb begin
    diff = $signed({1'b0, temp_raw, 8'h00}) - $signed({1'b0, acc_q});
    prod = diff * $signed({1'b0, smooth_gain(smooth_time)});
    step = prod[33:16];
    acc_d = acc_q;
    if (temp_stb) begin
      if (smooth_en) begin
        // One filter update per new sample; see [R15]
        acc_d = 16'($signed({2'b00, acc_q}) + step);
      end else begin
        acc_d = {temp_raw, 8'h00};
      end
    end
  end

  // Register the running value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= 16'h0000;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Only the control path sees the filtered value; raw readback is untouched
  assign temp_ctl = acc_q[15:8]; // see [R10]

  bypass_copy_a: assert property (@(posedge clk) disable iff (!nrst) // see [R10]
    (temp_stb && !smooth_en) |=> (temp_ctl == $past(temp_raw)))
    else $error("bypassed zone did not take the raw sample");

  smooth_hold_a: assert property (@(posedge clk) disable iff (!nrst) // see [R15]
    !temp_stb |=> $stable(acc_q))
    else $error("filter moved without a sample");

endmodule : afp_smooth
`default_nettype wire

/* File: hw/afp_params.sv */
// Per-zone automatic fan parameters: registers, smoothing, duty calculation and PWM
`timescale 1ns/1ps
`default_nettype none
`include "afp_defines.svh"
// Overview of operation
// [R01] Range code maps to sixteen spans, 2 to 80 C
// [R02] Minimum at limit, linear rise, full above
// [R03] Lock bit freezes all parameter registers
// [R04] Start clear uses default range and minimum
// [R05] Below limit: zero or minimum per fan bit
// [R06] Below-limit select bits sit at 7:5
// [R07] Per-zone smoothing enable bit positions
// [R08] Per-zone three-bit smoothing time fields
// [R09] Time codes map 35 s down to 0.8 s
// [R10] Smoothing affects control temperature only
// [R11] Software enables smoothing on processor zones
// [R12] Eight-bit minimum duty per fan, reset 80h
// [R13] Low-range duty equals value over 255
// [R14] Smoothing and select registers reset to zero
// [R15] Low-pass filter updated on each sample
module afp_params
  import afp_pkg::*;
#(
  parameter int SAMPLE_DS = 10 // Sample period in tenths of a second
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port from the management bus engine
  input wire afp_byte_t reg_addr,
  input wire logic reg_wr,
  input wire afp_byte_t reg_wdata,
  output afp_byte_t reg_rdata,
  // Bits of the lock/start control register
  input wire logic lock_bit,
  input wire logic start_bit,
  // Temperatures and limits per zone
  input wire logic temp_stb,
  input wire afp_byte_t zone1_temp,
  input wire afp_byte_t zone2_temp,
  input wire afp_byte_t zone3_temp,
  input wire afp_byte_t zone1_limit,
  input wire afp_byte_t zone2_limit,
  input wire afp_byte_t zone3_limit,
  // Duty and PWM per fan
  output afp_byte_t fan1_duty,
  output afp_byte_t fan2_duty,
  output afp_byte_t fan3_duty,
  output logic fan1_pwm,
  output logic fan2_pwm,
  output logic fan3_pwm
);

  // Reciprocal of the span times 65536; the span itself never needs storing.
  // Inexact entries are rounded up: rounding down would leave the top of the span one step short
  function automatic afp_gain_t range_recip(input afp_range_t sel);
    begin
      unique case (sel) // see [R01]
        4'h0: return 16'h8000; // 2 C
        4'h1: return 16'h6667; // 2.5 C
        4'h2: return 16'h4CCD; // 3.33 C
        4'h3: return 16'h4000; // 4 C
        4'h4: return 16'h3334; // 5 C
        4'h5: return 16'h2667; // 6.67 C
        4'h6: return 16'h2000; // 8 C
        4'h7: return 16'h199A; // 10 C
        4'h8: return 16'h1334; // 13.33 C
        4'h9: return 16'h1000; // 16 C
        4'hA: return 16'h0CCD; // 20 C
        4'hB: return 16'h099A; // 26.67 C
        4'hC: return 16'h0800; // 32 C
        4'hD: return 16'h0667; // 40 C
        4'hE: return 16'h04CD; // 53.33 C
        4'hF: return 16'h0334; // 80 C
      endcase
    end
  endfunction : range_recip

  // Fraction of the span reached, 16 fractional bits; at or past unity means full
  function automatic logic [23:0] span_frac(input afp_byte_t t, input afp_byte_t lim,
                                            input afp_range_t sel);
    afp_byte_t d;
    begin
      d = (t > lim) ? 8'(t - lim) : 8'h00;
      return {16'h0000, d} * {8'h00, range_recip(sel)};
    end
  endfunction : span_frac

  // Duty for one fan from its zone temperature
  function automatic afp_byte_t auto_duty(input afp_byte_t t, input afp_byte_t lim,
                                          input afp_range_t sel, input afp_byte_t mn,
                                          input logic below_min);
    logic [23:0] frac;
    logic [23:0] prod;
    begin
      frac = span_frac(t, lim, sel);
      prod = {16'h0000, 8'(`AFP_FULL_DUTY - mn)} * {8'h00, frac[15:0]};
      if (t < lim) begin
        return below_min ? mn : `AFP_ZERO_DUTY; // see [R05]
      end else if (frac >= 24'h01_0000) begin
        return `AFP_FULL_DUTY; // see [R02]
      end else begin
        return 8'(mn + prod[23:16]); // see [R02]
      end
    end
  endfunction : auto_duty

  // Register file state
  afp_byte_t range_q [3]; // Range nibble plus frequency nibble
  afp_byte_t range_d [3];
  afp_byte_t offmin_q; // Below-limit selects and zone 1 smoothing
  afp_byte_t offmin_d;
  afp_byte_t smooth23_q; // Zone 2 and zone 3 smoothing
  afp_byte_t smooth23_d;
  afp_byte_t min_q [3]; // Minimum duty per fan
  afp_byte_t min_d [3];
  afp_byte_t rdata_d;

  // Duty and PWM state
  afp_byte_t duty_q [3];
  afp_byte_t duty_d [3];
  afp_byte_t pwm_cnt_q; // Shared 255-step period counter
  afp_byte_t pwm_cnt_d;
  logic [2:0] pwm_q;
  logic [2:0] pwm_d;

  // Per-zone views
  afp_byte_t temp_raw [3];
  afp_byte_t temp_ctl [3];
  afp_byte_t limit [3];
  logic [2:0] smooth_en;
  afp_stime_t smooth_time [3];
  afp_range_t eff_range [3];
  afp_byte_t eff_min [3];
  logic [2:0] below_sel;

  assign temp_raw[0] = zone1_temp;
  assign temp_raw[1] = zone2_temp;
  assign temp_raw[2] = zone3_temp;
  assign limit[0] = zone1_limit;
  assign limit[1] = zone2_limit;
  assign limit[2] = zone3_limit;

  // Field extraction from the smoothing registers
  assign below_sel = offmin_q[`AFP_BELOW_SEL_LSB +: 3]; // see [R06]
  assign smooth_en[0] = offmin_q[`AFP_Z1_EN_BIT]; // see [R07]
  assign smooth_en[1] = smooth23_q[`AFP_Z2_EN_BIT]; // see [R07]
  assign smooth_en[2] = smooth23_q[`AFP_Z3_EN_BIT]; // see [R07]
  assign smooth_time[0] = offmin_q[`AFP_Z1_TIME_LSB +: 3]; // see [R08]
  assign smooth_time[1] = smooth23_q[`AFP_Z2_TIME_LSB +: 3]; // see [R08]
  assign smooth_time[2] = smooth23_q[`AFP_Z3_TIME_LSB +: 3]; // see [R08]

  // Register writes: dropped silently once locked; range and minimum writes are stored but not used before start
  always_comb begin
    range_d = range_q;
    offmin_d = offmin_q;
    smooth23_d = smooth23_q;
    min_d = min_q;
    if (reg_wr && !lock_bit) begin // see [R03]
      unique case (reg_addr)
        `AFP_ADDR_RANGE1: range_d[0] = reg_wdata;
        `AFP_ADDR_RANGE2: range_d[1] = reg_wdata;
        `AFP_ADDR_RANGE3: range_d[2] = reg_wdata;
        `AFP_ADDR_OFFMIN_Z1: offmin_d = reg_wdata & 8'hEF; // Reserved bit 4 stays zero
        `AFP_ADDR_Z2_Z3: smooth23_d = reg_wdata;
        `AFP_ADDR_MIN1: min_d[0] = reg_wdata; // see [R12]
        `AFP_ADDR_MIN2: min_d[1] = reg_wdata; // see [R12]
        `AFP_ADDR_MIN3: min_d[2] = reg_wdata; // see [R12]
        default: ; // Other addresses belong to other blocks
      endcase
    end
  end

  // Read data, one cycle after the address; unmapped offsets read zero
  always_comb begin
    unique case (reg_addr)
      `AFP_ADDR_RANGE1: rdata_d = range_q[0];
      `AFP_ADDR_RANGE2: rdata_d = range_q[1];
      `AFP_ADDR_RANGE3: rdata_d = range_q[2];
      `AFP_ADDR_OFFMIN_Z1: rdata_d = offmin_q;
      `AFP_ADDR_Z2_Z3: rdata_d = smooth23_q;
      `AFP_ADDR_MIN1: rdata_d = min_q[0];
      `AFP_ADDR_MIN2: rdata_d = min_q[1];
      `AFP_ADDR_MIN3: rdata_d = min_q[2];
      default: rdata_d = 8'h00;
    endcase
  end

  // Register file flops with their reset values
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      range_q <= '{`AFP_RANGE_RST, `AFP_RANGE_RST, `AFP_RANGE_RST};
      offmin_q <= `AFP_SMOOTH_RST; // see [R14]
      smooth23_q <= `AFP_SMOOTH_RST; // see [R14]
      min_q <= '{`AFP_MIN_RST, `AFP_MIN_RST, `AFP_MIN_RST}; // see [R12]
      reg_rdata <= 8'h00;
    end else begin
      range_q <= range_d;
      offmin_q <= offmin_d;
      smooth23_q <= smooth23_d;
      min_q <= min_d;
      reg_rdata <= rdata_d;
    end
  end

  // Smoothing filters, one per zone; the host decides which zones use them (see [R11])
  for (genvar z = 0; z < 3; z++) begin : g_zone
    afp_smooth #(
      .SAMPLE_DS(SAMPLE_DS)
    ) u_smooth (
      .clk(clk),
      .nrst(nrst),
      .temp_stb(temp_stb),
      .temp_raw(temp_raw[z]),
      .smooth_en(smooth_en[z]),
      .smooth_time(smooth_time[z]),
      .temp_ctl(temp_ctl[z])
    );
  end

  // Effective settings: defaults stand in until start is set
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      eff_range[i] = start_bit ? range_q[i][`AFP_RANGE_LSB +: 4]
                               : 4'(`AFP_RANGE_RST >> `AFP_RANGE_LSB); // see [R04]
      eff_min[i] = start_bit ? min_q[i] : `AFP_MIN_RST; // see [R04]
    end
  end

  // Duty per fan and the PWM compare; a duty of FFh never drops because the count wraps to 00h after FEh
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      duty_d[i] = auto_duty(temp_ctl[i], limit[i], eff_range[i], eff_min[i], below_sel[i]);
      pwm_d[i] = (pwm_cnt_q < duty_q[i]); // see [R13]
    end
    pwm_cnt_d = (pwm_cnt_q == `AFP_PWM_LAST) ? 8'h00 : 8'(pwm_cnt_q + 8'h01); // see [R13]
  end

  // Duty and PWM flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      duty_q <= '{8'h00, 8'h00, 8'h00};
      pwm_cnt_q <= 8'h00;
      pwm_q <= 3'b000;
    end else begin
      duty_q <= duty_d;
      pwm_cnt_q <= pwm_cnt_d;
      pwm_q <= pwm_d;
    end
  end

  assign fan1_duty = duty_q[0];
  assign fan2_duty = duty_q[1];
  assign fan3_duty = duty_q[2];
  assign fan1_pwm = pwm_q[0];
  assign fan2_pwm = pwm_q[1];
  assign fan3_pwm = pwm_q[2];

  lock_freeze_a: assert property (@(posedge clk) disable iff (!nrst) // see [R03]
    (reg_wr && lock_bit) |=> ($stable(offmin_q) && $stable(smooth23_q) && $stable(min_q[0])
                              && $stable(range_q[0])))
    else $error("locked register changed on a write");

  min_store_a: assert property (@(posedge clk) disable iff (!nrst) // see [R12]
    (reg_wr && !lock_bit && reg_addr == `AFP_ADDR_MIN1) |=> (min_q[0] == $past(reg_wdata)))
    else $error("minimum duty write not stored");

  below_zero_a: assert property (@(posedge clk) disable iff (!nrst) // see [R05]
    (temp_ctl[0] < limit[0] && !below_sel[0]) |=> (fan1_duty == 8'h00))
    else $error("fan 1 not off below limit");

  below_min_a: assert property (@(posedge clk) disable iff (!nrst) // see [R05]
    (temp_ctl[1] < limit[1] && below_sel[1]) |=> (fan2_duty == $past(eff_min[1])))
    else $error("fan 2 not at minimum below limit");

  limit_min_a: assert property (@(posedge clk) disable iff (!nrst) // see [R02]
    (temp_ctl[0] == limit[0] && !start_bit) |=> (fan1_duty == 8'h80))
    else $error("default minimum not applied at limit");

  span_full_a: assert property (@(posedge clk) disable iff (!nrst) // see [R02]
    (temp_ctl[2] >= limit[2] && span_frac(temp_ctl[2], limit[2], eff_range[2]) >= 24'h01_0000)
    |=> (fan3_duty == 8'hFF))
    else $error("fan 3 not full past the span");

  rdata_map_a: assert property (@(posedge clk) disable iff (!nrst) // see [R14]
    (reg_addr == `AFP_ADDR_OFFMIN_Z1) |=> (reg_rdata[4] == 1'b0 && reg_rdata == $past(offmin_q)))
    else $error("smoothing register readback wrong");

  pwm_full_a: assert property (@(posedge clk) disable iff (!nrst) // see [R13]
    (fan1_duty == 8'hFF) [*2] |=> fan1_pwm)
    else $error("full duty output dropped");

  pwm_zero_a: assert property (@(posedge clk) disable iff (!nrst) // see [R13]
    (fan2_duty == 8'h00) [*2] |=> !fan2_pwm)
    else $error("zero duty output raised");

endmodule : afp_params
`default_nettype wire

/* File: tb/afp_fan_model.sv */
// Fan drive model: measures the high time of each PWM line over 255-clock windows
`timescale 1ns/1ps
`default_nettype none
module afp_fan_model
  import afp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // PWM lines from the block
  input wire logic [2:0] pwm,
  // Measured duty per fan and its one-cycle strobe
  output afp_byte_t meas [3],
  output logic meas_stb
);
  afp_byte_t win_q; // Position inside the window
  afp_byte_t hi_q [3]; // High cycles counted so far
  // A window of 255 clocks spans one PWM period, so the high count reads as value/255
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      win_q <= 8'h00;
      meas_stb <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        hi_q[i] <= 8'h00;
        meas[i] <= 8'h00;
      end
    end else begin
      meas_stb <= (win_q == 8'hFE);
      win_q <= (win_q == 8'hFE) ? 8'h00 : win_q + 8'h01;
      for (int i = 0; i < 3; i++) begin
        // Window end: publish and restart the count
        if (win_q == 8'hFE) begin
          meas[i] <= hi_q[i] + {7'h00, pwm[i]};
          hi_q[i] <= 8'h00;
        end else begin
          hi_q[i] <= hi_q[i] + {7'h00, pwm[i]};
        end
      end
    end
  end
endmodule : afp_fan_model
`default_nettype wire

/* File: tb/test_auto_fan_pwm_params.sv */
// Self-checking bench of the fan parameter block
`timescale 1ns/1ps
`default_nettype none
`include "afp_defines.svh"
module test_auto_fan_pwm_params
  import afp_pkg::*;
();
  // One table row: zone input, settings and the duty they should give
  typedef struct packed {
    afp_byte_t t;
    afp_byte_t lim;
    logic sel;
    afp_byte_t mn;
    afp_range_t rc;
    afp_byte_t exp;
  } afp_row_t;
  logic clk, nrst, reg_wr, lock_bit, start_bit, temp_stb, meas_stb;
  afp_byte_t reg_addr, reg_wdata, reg_rdata;
  afp_byte_t zt [3]; // Zone temperatures
  afp_byte_t zl [3]; // Zone limits
  afp_byte_t duty [3];
  afp_byte_t meas [3]; // Duty seen by the fan model
  logic [2:0] pwm;
  int fails, checks_done;
  afp_row_t r;
  // Below limit, at limit, mid span, span ends of several range codes
  afp_row_t rows [10] = '{
    '{8'h28, 8'h32, 1'b0, 8'h32, 4'h6, 8'h00}, '{8'h28, 8'h32, 1'b1, 8'h32, 4'h6, 8'h32},
    '{8'h32, 8'h32, 1'b0, 8'h32, 4'h6, 8'h32}, '{8'h36, 8'h32, 1'b0, 8'h32, 4'h6, 8'h98},
    '{8'h3A, 8'h32, 1'b0, 8'h32, 4'h6, 8'hFF}, '{8'h41, 8'h32, 1'b0, 8'h00, 4'h9, 8'hEF},
    '{8'h42, 8'h32, 1'b0, 8'h00, 4'h9, 8'hFF}, '{8'h33, 8'h32, 1'b0, 8'h00, 4'h0, 8'h7F},
    '{8'h42, 8'h32, 1'b0, 8'h80, 4'hC, 8'hBF}, '{8'h82, 8'h32, 1'b0, 8'h00, 4'hF, 8'hFF}};
  afp_byte_t rst_exp [8] = '{8'hC4, 8'hC4, 8'hC4, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80};

  // Small SAMPLE_DS gives gain 1/2 for smoothing code 111, so the filter settles quickly
  afp_params #(.SAMPLE_DS(4)) dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .lock_bit(lock_bit), .start_bit(start_bit), .temp_stb(temp_stb),
    .zone1_temp(zt[0]), .zone2_temp(zt[1]), .zone3_temp(zt[2]), .zone1_limit(zl[0]),
    .zone2_limit(zl[1]), .zone3_limit(zl[2]), .fan1_duty(duty[0]), .fan2_duty(duty[1]),
    .fan3_duty(duty[2]), .fan1_pwm(pwm[0]), .fan2_pwm(pwm[1]), .fan3_pwm(pwm[2]));
  afp_fan_model fan (.clk(clk), .nrst(nrst), .pwm(pwm), .meas(meas), .meas_stb(meas_stb));

  // 20 MHz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Compare and count
  task automatic check(input afp_byte_t seen, input afp_byte_t exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic chk3(input afp_byte_t a, input afp_byte_t b, input afp_byte_t c);
    check(duty[0], a);
    check(duty[1], b);
    check(duty[2], c);
  endtask : chk3

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // One-cycle write pulse; a clock always passes with the strobe low between writes
  task automatic wr(input afp_byte_t a, input afp_byte_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is registered one cycle after the address
  task automatic rd_check(input afp_byte_t a, input afp_byte_t e);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1;
    check(reg_rdata, e);
  endtask : rd_check

  // New sample on all zones; duty is due two cycles after the strobe edge
  task automatic strobe(input afp_byte_t a, input afp_byte_t b, input afp_byte_t c);
    @(posedge clk);
    zt[0] <= a;
    zt[1] <= b;
    zt[2] <= c;
    temp_stb <= 1'b1;
    @(posedge clk);
    temp_stb <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : strobe

  // Bounded wait for the end of a measuring window
  task automatic wait_window();
    int n;
    n = 0;
    while (meas_stb !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 600) begin
        fails++;
        report_and_stop();
      end
    end
    @(posedge clk);
    #1;
  endtask : wait_window

  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    lock_bit = 1'b0;
    start_bit = 1'b0;
    temp_stb = 1'b0;
    zt = '{8'h00, 8'h00, 8'h00};
    zl = '{8'h32, 8'h32, 8'h32};
    fails = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) rd_check(`AFP_ADDR_RANGE1 + 8'(i), rst_exp[i]);
    rd_check(8'h70, 8'h00);
    wr(`AFP_ADDR_OFFMIN_Z1, 8'hFF);
    rd_check(`AFP_ADDR_OFFMIN_Z1, 8'hEF);
    wr(`AFP_ADDR_Z2_Z3, 8'hA5);
    rd_check(`AFP_ADDR_Z2_Z3, 8'hA5);
    wr(`AFP_ADDR_Z2_Z3, 8'h00);
    $display("test registers done");
    @(posedge clk) start_bit <= 1'b1;
    // Table of automatic duty cases, the same settings on all three fans
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      zl <= '{r.lim, r.lim, r.lim};
      for (int f = 0; f < 3; f++) begin
        wr(`AFP_ADDR_RANGE1 + 8'(f), {r.rc, 4'h0});
        wr(`AFP_ADDR_MIN1 + 8'(f), r.mn);
      end
      wr(`AFP_ADDR_OFFMIN_Z1, r.sel ? 8'hE0 : 8'h00);
      strobe(r.t, r.t, r.t);
      chk3(r.exp, r.exp, r.exp);
      wait_window();
      wait_window();
      for (int f = 0; f < 3; f++) check(meas[f], r.exp);
    end
    $display("test duty table done");
    // Smoothing: zones 1 and 2 filtered, zone 3 follows the raw sample
    for (int f = 0; f < 3; f++) wr(`AFP_ADDR_RANGE1 + 8'(f), 8'h60);
    wr(`AFP_ADDR_OFFMIN_Z1, 8'h00);
    strobe(8'h32, 8'h32, 8'h32);
    wr(`AFP_ADDR_OFFMIN_Z1, 8'h0F);
    wr(`AFP_ADDR_Z2_Z3, 8'hF0);
    strobe(8'h3A, 8'h3A, 8'h3A);
    chk3(8'h7F, 8'h7F, 8'hFF);
    strobe(8'h3A, 8'h3A, 8'h3A);
    chk3(8'hBF, 8'hBF, 8'hFF);
    $display("test smoothing done");
    // Start clear: stored range and minimum are ignored in favour of the defaults
    wr(`AFP_ADDR_OFFMIN_Z1, 8'h00);
    wr(`AFP_ADDR_Z2_Z3, 8'h00);
    for (int f = 0; f < 3; f++) wr(`AFP_ADDR_RANGE1 + 8'(f), 8'h00);
    @(posedge clk) start_bit <= 1'b0;
    strobe(8'h42, 8'h42, 8'h42);
    chk3(8'hBF, 8'hBF, 8'hBF);
    // At the limit the default minimum stands in for the stored 00h
    strobe(8'h32, 8'h32, 8'h32);
    chk3(8'h80, 8'h80, 8'h80);
    rd_check(`AFP_ADDR_MIN1, 8'h00);
    $display("test start done");
    // Lock set: writes are dropped silently
    @(posedge clk) lock_bit <= 1'b1;
    wr(`AFP_ADDR_MIN1, 8'h55);
    wr(`AFP_ADDR_OFFMIN_Z1, 8'hE0);
    wr(`AFP_ADDR_RANGE1, 8'hF0);
    rd_check(`AFP_ADDR_MIN1, 8'h00);
    rd_check(`AFP_ADDR_OFFMIN_Z1, 8'h00);
    rd_check(`AFP_ADDR_RANGE1, 8'h00);
    $display("test lock done");
    report_and_stop();
  end
endmodule : test_auto_fan_pwm_params
`default_nettype wire
